// ==== tb/addressable_shift_register_tb_top.sv ====
`timescale 1ns/10ps
module addressable_shift_register_tb_top;
  localparam int TIMEOUT = 4000;
  localparam int DEPTH   = shift_chain_pkg::FIFO_DEPTH;

  logic         ref_clk, resetn, valid, ready, ce, split, slow, upper, cascade, chain, sync;
  logic [1:0]   data;
  logic [6:0]   tap;
  logic [3:0]   main_out, last_out;
  logic [31:0]  rnd;
  logic [127:0] ref_bits;
  logic [1:0]   ent;
  logic         prev_chain, full, exp_main;
  logic [1:0]   fifo_q[$];
  int           err_count, n_checks, cycles, e;
  int           taps[4] = '{0, 12, 31, 127};

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // unknown expectations are skipped: stored bits are undefined until flushed
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    if (exp !== 1'bx) begin
      n_checks++;
      if (got !== exp) begin
        err_count++;
        $display("FAIL %0t %s got %b exp %b tap %0d", $time, what, got, exp, tap);
      end
    end
  endtask

  // ****************************************
  // drive phases
  // ****************************************
  task automatic run(input int n, input int ce_mode, input int fixed, input logic sp);
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      ce    = (ce_mode == 2) ? rnd[5] : ce_mode[0];
      tap   = (fixed < 0) ? rnd[12:6] : fixed[6:0];
      split = sp;
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  fabric_bit_source far_end (
    .ref_clk_i (ref_clk),
    .resetn_i  (resetn),
    .ready_i   (ready),
    .slow_i    (slow),
    .rnd_i     (rnd[2:0]),
    .valid_o   (valid),
    .data_o    (data)
  );

  addressable_shift_register dut (
    .ref_clk_i           (ref_clk),
    .resetn_i            (resetn),
    .serial_shift_in_i   (data[0]),
    .split_shift_in_i    (data[1]),
    .shift_valid_i       (valid),
    .shift_ready_o       (ready),
    .shift_ce_i          (ce),
    .split_mode_i        (split),
    .tap_addr_i          (tap),
    .element_main_out_o  (main_out),
    .split_upper_out_o   (upper),
    .last_bit_out_o      (last_out),
    .cascade_shift_out_o (cascade),
    .chain_bit_out_o     (chain),
    .chain_bit_sync_o    (sync)
  );

  // ****************************************
  // reference chain and buffer
  // ****************************************
  always @(posedge ref_clk) begin
    rnd = lfsr_next(rnd);
    cycles++;
    if (cycles == TIMEOUT) begin
      err_count++;
      conclude();
    end
    // buffer is cleared by reset, stored bits are not
    if (!resetn) begin
      fifo_q.delete();
    end else begin
      full = (fifo_q.size() == DEPTH);
      if (ce && fifo_q.size() > 0) begin
        ent      = fifo_q.pop_front();
        ref_bits = {ref_bits[126:0], ent[0]};
        if (split) begin
          ref_bits[16] = ent[1];
        end
      end
      if (valid && !full) begin
        fifo_q.push_back(data);
      end
    end
  end

  always @(negedge ref_clk) begin
    if (resetn) begin
      cmp_bit(ready, fifo_q.size() < DEPTH, "buffer ready");
      cmp_bit(chain, ref_bits[tap], "chain read");
      cmp_bit(sync, prev_chain, "sync read");
      cmp_bit(cascade, ref_bits[127], "cascade out");
      cmp_bit(upper, ref_bits[16 + tap[3:0]], "split upper");
      for (e = 0; e < 4; e++) begin
        exp_main = (e == 0 && split) ? ref_bits[tap[3:0]] : ref_bits[32 * e + tap[4:0]];
        cmp_bit(last_out[e], ref_bits[32 * e + 31], "last bit");
        cmp_bit(main_out[e], exp_main, "main out");
      end
    end
    prev_chain = resetn ? ref_bits[tap] : 1'bx;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    resetn     = 1'b0;
    ce         = 1'b0;
    split      = 1'b0;
    slow       = 1'b0;
    tap        = 7'h00;
    rnd        = 32'h00017674;
    ref_bits   = 'x;
    prev_chain = 1'bx;
    err_count  = 0;
    n_checks   = 0;
    cycles     = 0;
    repeat (12) @(posedge ref_clk);
    #1 resetn = 1'b1;
    run(300, 1, -1, 1'b0);
    run(24, 0, -1, 1'b0);
    slow = 1'b1;
    run(60, 1, -1, 1'b0);
    slow = 1'b0;
    foreach (taps[i]) begin
      run(150, 2, taps[i], 1'b0);
    end
    run(200, 2, -1, 1'b1);
    // a reset in mid-run must leave the stored bits alone
    @(posedge ref_clk);
    #1 resetn = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1'b1;
    run(100, 1, -1, 1'b0);
    conclude();
  end
endmodule

// ==== tb/fabric_bit_source.sv ====
`timescale 1ns/10ps
module fabric_bit_source (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  input  wire logic       ready_i,
  input  wire logic       slow_i,
  input  wire logic [2:0] rnd_i,
  output logic            valid_o,
  output logic [1:0]      data_o
);
  // ****************************************
  // fabric logic feeding the shift buffer
  // ****************************************
  logic took;

  initial begin
    valid_o = 1'b0;
    data_o  = 2'h0;
  end

  // lowest lookup input tie-high has no port here, kept by whoever sets up
  // request and data held until ready is seen high at an edge
  always begin
    @(posedge ref_clk_i);
    took = valid_o && ready_i;
    #1;
    if (!resetn_i) begin
      valid_o = 1'b0;
      data_o  = ~data_o;
    end else if (took || !valid_o) begin
      // slow mode leaves gaps so the buffer runs dry
      valid_o = !slow_i || rnd_i[2];
      data_o  = rnd_i[1:0];
    end
  end
endmodule

// ==== verilog/addressable_shift_register.sv ====
`timescale 1ns/10ps
module addressable_shift_register (
  input  wire logic                                    ref_clk_i,
  input  wire logic                                    resetn_i,
  input  wire logic                                    serial_shift_in_i,
  input  wire logic                                    split_shift_in_i,
  input  wire logic                                    shift_valid_i,
  output logic                                         shift_ready_o,
  input  wire logic                                    shift_ce_i,
  input  wire logic                                    split_mode_i,
  input  wire logic [shift_chain_pkg::CHAIN_TAP_W-1:0] tap_addr_i,
  output logic      [shift_chain_pkg::ELEM_COUNT-1:0]  element_main_out_o,
  output logic                                         split_upper_out_o,
  output logic      [shift_chain_pkg::ELEM_COUNT-1:0]  last_bit_out_o,
  output logic                                         cascade_shift_out_o,
  output logic                                         chain_bit_out_o,
  output logic                                         chain_bit_sync_o
);

  // ****************************************
  // tap helpers
  // ****************************************
  function automatic logic tap_bit(
    input shift_chain_pkg::elem_type           v,
    input logic [shift_chain_pkg::TAP_W-1:0] a
  );
    tap_bit = v[a];
  endfunction

  function automatic logic half_tap(
    input shift_chain_pkg::elem_type                v,
    input logic                                     upper,
    input logic [shift_chain_pkg::HALF_TAP_W-1:0] a
  );
    logic [shift_chain_pkg::TAP_W-1:0] idx;
    idx      = {upper, a};
    half_tap = v[idx];
  endfunction

  shift_chain_pkg::chain_state_type state_q;
  shift_chain_pkg::chain_state_type state_d;

  bit_stream_if in_stream ();
  bit_stream_if out_stream ();

  logic                                 shift;
  logic                                 din_main;
  logic                                 din_split;
  logic [shift_chain_pkg::TAP_W-1:0]    low_addr;
  logic [shift_chain_pkg::HALF_TAP_W-1:0] half_addr;
  logic [shift_chain_pkg::ELEM_COUNT-1:0] elem_tap;
  logic                                 lower_pair_mux;
  logic                                 upper_pair_mux;
  logic                                 quad_select_mux;
  logic                                 below_tap;

  // ****************************************
  // input buffer
  // ****************************************
  // the buffer lets the feeding logic run ahead while the enable is low
  assign in_stream.valid = shift_valid_i;
  assign in_stream.data  = {split_shift_in_i, serial_shift_in_i};
  assign shift_ready_o   = in_stream.ready;

  bit_fifo #(
    .WIDTH (shift_chain_pkg::FIFO_WIDTH),
    .DEPTH (shift_chain_pkg::FIFO_DEPTH)
  ) u_in_fifo (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .fill      (in_stream.sink),
    .drain     (out_stream.source)
  );

  // the clock enable doubles as the drain side ready, so a low enable fills the buffer
  assign out_stream.ready = shift_ce_i;
  assign shift     = out_stream.valid && shift_ce_i && resetn_i;
  assign din_main  = out_stream.data[shift_chain_pkg::FIFO_MAIN];
  assign din_split = out_stream.data[shift_chain_pkg::FIFO_SPLIT];

  // ****************************************
  // shift path
  // ****************************************
  always_comb begin
    state_d = state_q;
    if (shift) begin
      state_d.store[0] = {state_q.store[0][shift_chain_pkg::LAST_BIT-1:0], din_main};
      if (split_mode_i) begin
        // upper half becomes a second register on its own input
        state_d.store[0][shift_chain_pkg::HALF_BITS] = din_split;
      end
      for (int e = 1; e < shift_chain_pkg::ELEM_COUNT; e++) begin
        // cascade bit of the previous element enters bit zero
        state_d.store[e] = {state_q.store[e][shift_chain_pkg::LAST_BIT-1:0],
                            state_q.store[e-1][shift_chain_pkg::LAST_BIT]};
      end
    end
    // output flip-flop samples the live chain read every edge
    state_d.sync_tap = quad_select_mux;
  end

  // reset clears only the output flip-flop; storage keeps its bits and holds whatever it powered up with
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_q.store    <= state_d.store;
      state_q.sync_tap <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  assign low_addr  = tap_addr_i[shift_chain_pkg::TAP_W-1:0];
  assign half_addr = tap_addr_i[shift_chain_pkg::HALF_TAP_W-1:0];

  always_comb begin
    for (int e = 0; e < shift_chain_pkg::ELEM_COUNT; e++) begin
      elem_tap[e]       = tap_bit(state_q.store[e], low_addr);
      last_bit_out_o[e] = state_q.store[e][shift_chain_pkg::LAST_BIT];
    end
    element_main_out_o = elem_tap;
    if (split_mode_i) begin
      element_main_out_o[0] = half_tap(state_q.store[0], 1'b0, half_addr);
    end
  end

  assign split_upper_out_o = half_tap(state_q.store[0], 1'b1, half_addr);

  // only the far end of the group drives the cascade pin
  assign cascade_shift_out_o =
    state_q.store[shift_chain_pkg::LAST_ELEM][shift_chain_pkg::LAST_BIT];

  // pair then quad selection keeps the wide read to two mux levels
  assign lower_pair_mux  = tap_addr_i[shift_chain_pkg::PAIR_SEL] ? elem_tap[1] : elem_tap[0];
  assign upper_pair_mux  = tap_addr_i[shift_chain_pkg::PAIR_SEL] ? elem_tap[3] : elem_tap[2];
  assign quad_select_mux = tap_addr_i[shift_chain_pkg::QUAD_SEL] ? upper_pair_mux
                                                                 : lower_pair_mux;
  assign chain_bit_out_o  = quad_select_mux;
  assign chain_bit_sync_o = state_q.sync_tap;

  // ****************************************
  // checks
  // ****************************************
  // the bit one place below the tap, which a shift moves into the tap
  assign below_tap = tap_bit(state_q.store[0], low_addr - 1'b1);

  sequence s_shift_fixed_tap;
    shift && !split_mode_i && (low_addr != '0) ##1 $stable(tap_addr_i) && !split_mode_i;
  endsequence

  sequence s_idle_fixed_tap;
    !shift ##1 $stable(tap_addr_i) && $stable(split_mode_i);
  endsequence

  // stored bits stay unknown until flushed, so checks on moved bits use case equality; the input load checks use ==
  a_bit_zero_load: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift |=> state_q.store[0][0] == $past(din_main))
    else $error("serial input not stored in bit zero");

  a_bits_move_up: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift && !split_mode_i |=>
      state_q.store[0][shift_chain_pkg::LAST_BIT:1] ===
      $past(state_q.store[0][shift_chain_pkg::LAST_BIT-1:0]))
    else $error("stored bits did not move up one place");

  a_chain_link_feed: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift |=> state_q.store[1][0] === $past(last_bit_out_o[0]))
    else $error("cascade bit did not enter next element");

  a_hold_without_ce: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !shift |=> $stable(state_q.store))
    else $error("storage changed without a shift");

  a_cascade_last_bit: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift |=> cascade_shift_out_o ===
      $past(state_q.store[shift_chain_pkg::LAST_ELEM][shift_chain_pkg::LAST_BIT-1]))
    else $error("cascade output is not the last stored bit");

  a_sync_one_late: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> chain_bit_sync_o === $past(chain_bit_out_o))
    else $error("synchronous read not exactly one cycle late");

  a_tap_follows_addr: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !split_mode_i |-> element_main_out_o[0] === state_q.store[0][low_addr])
    else $error("main output does not follow tap address");

  a_fixed_tap_shift: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_shift_fixed_tap |-> element_main_out_o[0] === $past(below_tap))
    else $error("fixed tap did not present the moved bit");

  a_fixed_tap_quiet: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_idle_fixed_tap |-> $stable(element_main_out_o))
    else $error("main output changed without a shift");

  a_split_upper_load: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift && split_mode_i |=>
      state_q.store[0][shift_chain_pkg::HALF_BITS] == $past(din_split))
    else $error("upper half did not take its own input");

  a_quad_tap_select: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    chain_bit_out_o === state_q.store[tap_addr_i[shift_chain_pkg::QUAD_SEL:
                                                 shift_chain_pkg::PAIR_SEL]][low_addr])
    else $error("chain read picked the wrong element");

  // ****************************************
  // chain checks
  // ****************************************
  // independent of the mux tree, so a miswired pair or quad level shows up here
  function automatic logic chain_read(
    input shift_chain_pkg::chain_state_type        s,
    input logic [shift_chain_pkg::CHAIN_TAP_W-1:0] a
  );
    chain_read = s.store[a[shift_chain_pkg::QUAD_SEL:shift_chain_pkg::PAIR_SEL]]
                        [a[shift_chain_pkg::TAP_W-1:0]];
  endfunction

  logic [shift_chain_pkg::CHAIN_TAP_W-1:0] below_addr;
  logic                                    below_chain;

  assign below_addr  = tap_addr_i - 1'b1;
  assign below_chain = chain_read(state_q, below_addr);

  sequence s_chain_fixed_shift;
    shift && !split_mode_i && (tap_addr_i != '0) ##1 $stable(tap_addr_i);
  endsequence

  sequence s_chain_head_shift;
    shift && (tap_addr_i == '0) ##1 (tap_addr_i == '0);
  endsequence

  sequence s_chain_idle;
    !shift ##1 $stable(tap_addr_i);
  endsequence

  a_chain_fixed_shift: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_chain_fixed_shift |-> chain_bit_out_o === $past(below_chain))
    else $error("fixed chain tap did not present the moved bit");

  a_chain_head_shift: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_chain_head_shift |-> chain_bit_out_o == $past(din_main))
    else $error("tap zero did not give a one cycle delay");

  a_chain_quiet: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    s_chain_idle |-> $stable(chain_bit_out_o))
    else $error("chain read changed without a shift");

  a_link_second_feed: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift |=> state_q.store[2][0] === $past(state_q.store[1][shift_chain_pkg::LAST_BIT]))
    else $error("second link did not pass the last bit");

  a_link_third_feed: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift |=> state_q.store[3][0] === $past(state_q.store[2][shift_chain_pkg::LAST_BIT]))
    else $error("third link did not pass the last bit");

  a_far_bits_move: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift |=>
      state_q.store[shift_chain_pkg::LAST_ELEM][shift_chain_pkg::LAST_BIT:1] ===
      $past(state_q.store[shift_chain_pkg::LAST_ELEM][shift_chain_pkg::LAST_BIT-1:0]))
    else $error("far element bits did not move up one place");

  // ****************************************
  // split and output checks
  // ****************************************
  a_split_lower_move: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift && split_mode_i |=>
      state_q.store[0][shift_chain_pkg::HALF_BITS-1:1] ===
      $past(state_q.store[0][shift_chain_pkg::HALF_BITS-2:0]))
    else $error("lower half did not move up one place");

  a_split_upper_move: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    shift && split_mode_i |=>
      state_q.store[0][shift_chain_pkg::LAST_BIT:shift_chain_pkg::HALF_BITS+1] ===
      $past(state_q.store[0][shift_chain_pkg::LAST_BIT-1:shift_chain_pkg::HALF_BITS]))
    else $error("upper half did not move up one place");

  a_split_lower_read: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    split_mode_i |-> element_main_out_o[0] === state_q.store[0][half_addr])
    else $error("lower half read picked the wrong bit");

  a_split_upper_read: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    split_upper_out_o === state_q.store[0][shift_chain_pkg::HALF_BITS + half_addr])
    else $error("upper half read picked the wrong bit");

  a_cascade_quiet: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !shift |=> $stable(cascade_shift_out_o))
    else $error("cascade output changed without a shift");

  a_last_bits_quiet: assert property (
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !shift |=> $stable(last_bit_out_o))
    else $error("last bit outputs changed without a shift");

  // these two watch the reset itself, so they carry no disable
  a_sync_reset_low: assert property (
    @(posedge ref_clk_i)
    !resetn_i |=> !chain_bit_sync_o)
    else $error("synchronous read flop not cleared by reset");

  a_ready_after_reset: assert property (
    @(posedge ref_clk_i)
    !resetn_i |=> shift_ready_o)
    else $error("buffer not ready after reset");

endmodule

// ==== verilog/bit_fifo.sv ====
`timescale 1ns/10ps
module bit_fifo #(
  parameter int WIDTH = shift_chain_pkg::FIFO_WIDTH,
  parameter int DEPTH = shift_chain_pkg::FIFO_DEPTH
) (
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  bit_stream_if.sink      fill,
  bit_stream_if.source    drain
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_SLOT  = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            wr_ptr;
    logic [PTR_W-1:0]            rd_ptr;
    logic [CNT_W-1:0]            count;
  } fifo_state_type;

  fifo_state_type state_q;
  fifo_state_type state_d;
  logic           push;
  logic           pop;

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    ptr_next = (p == LAST_SLOT) ? '0 : p + 1'b1;
  endfunction

  // ****************************************
  // handshake
  // ****************************************
  assign fill.ready  = (state_q.count != FULL_COUNT);
  assign drain.valid = (state_q.count != '0);
  assign drain.data  = state_q.mem[state_q.rd_ptr];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  always_comb begin
    state_d = state_q;
    if (push) begin
      state_d.mem[state_q.wr_ptr] = fill.data;
      state_d.wr_ptr              = ptr_next(state_q.wr_ptr);
    end
    if (pop) begin
      state_d.rd_ptr = ptr_next(state_q.rd_ptr);
    end
    if (push && !pop) begin
      state_d.count = state_q.count + 1'b1;
    end else if (pop && !push) begin
      state_d.count = state_q.count - 1'b1;
    end
  end

  // pointers and count reset; the slots need not, nothing reads an empty slot
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_q.mem    <= state_d.mem;
      state_q.wr_ptr <= '0;
      state_q.rd_ptr <= '0;
      state_q.count  <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  a_fifo_count_step: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (push && !pop) |=> state_q.count == $past(state_q.count) + 1'b1)
    else $error("fifo count did not rise on push");

endmodule

// ==== verilog/bit_stream_if.sv ====
`timescale 1ns/10ps
interface bit_stream_if;
  logic                                 valid;
  logic                                 ready;
  logic [shift_chain_pkg::FIFO_WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ==== verilog/shift_chain_pkg.sv ====
// Functional notes
// - each element holds 32 bits and can delay the serial input by any amount from 1 to 32 edges.
// - the cascade bit of one element feeds the shift input of the next, so four give up to 128.
// - only the far end of the group drives the cascade output; longer chains use plain routing.
// - the stored bits change only on the clock edge and only while the clock enable is high.
// - a five-bit tap address picks which of the 32 bits of an element shows on its main output.
// - the stored bits have no set or reset path of any kind.
// - the optional output flip-flop presents the tap read exactly one cycle after the live read.
// - a shift stores the serial input in bit zero and moves every bit up one place in one edge, save that in split mode bit 16 takes the split input.
// - the cascade output always carries the last stored bit and changes only after a shift.
// - the main output follows the applied tap address at once, whatever the clock and enable do.
// - with the tap address fixed at N the element acts as a shift register of length N plus one.
// - with a fixed tap address the main output changes only with a shift, showing the moved bit.
// - one element can work as two independent 16-bit shift registers.
// - chained elements and the wide muxes give a 128-bit register with access to any bit.
package shift_chain_pkg;

  localparam int ELEM_BITS   = 32;
  localparam int ELEM_COUNT  = 4;
  localparam int CHAIN_BITS  = ELEM_BITS * ELEM_COUNT;
  localparam int TAP_W       = 5;
  localparam int CHAIN_TAP_W = 7;
  localparam int HALF_BITS   = 16;
  localparam int HALF_TAP_W  = 4;
  localparam int PAIR_SEL    = 5;
  localparam int QUAD_SEL    = 6;
  localparam int LAST_BIT    = ELEM_BITS - 1;
  localparam int LAST_ELEM   = ELEM_COUNT - 1;

  // ****************************************
  // input buffer
  // ****************************************
  localparam int FIFO_WIDTH  = 2;
  localparam int FIFO_DEPTH  = 16;
  localparam int FIFO_MAIN   = 0;
  localparam int FIFO_SPLIT  = 1;

  typedef logic [ELEM_BITS-1:0] elem_type;

  typedef struct packed {
    elem_type [ELEM_COUNT-1:0] store;
    logic                      sync_tap;
  } chain_state_type;

endpackage
